// ### inc/iwdt_pkg.sv
// Purpose: Shared constants and types for the interval/watchdog timer and its CPU-side end
// Assumes: One 50 MHz clock; slow oscillator ticks come from a divider enable
// Notes:   I/O map is byte addressed on an 8-bit bus
//
// Summary of operation
// [R1] 16-bit registers move as two byte accesses
// [R2] One shared high-byte latch per 16-bit timer
// [R3] Low-byte write loads latch plus low byte
// [R4] Low-byte read copies high byte into latch
// [R5] Host writes high first, reads low first
// [R6] Host keeps two-byte accesses uninterrupted
// [R7] Latch keeps value after low-byte write
// [R8] Interval timer runs from 90 kHz oscillator
// [R9] Twenty-stage divider feeds interval and prescaler outputs
// [R10] Interval irq gated; two 3-bit stage selects
// [R11] Divider runs by itself after reset
// [R12] Restart bit restarts divider when watchdog idle
// [R13] Three-bit watchdog counter overflow requests reset
// [R14] Restart instruction clears watchdog counter in time
// [R15] Counter cleared when disabled or on reset
// [R16] Three-bit select picks watchdog step tap
// [R17] Fuse level 1: starts off, timed changes
// [R18] Fuse level 2: always on, timed changes
// [R19] Control only through CPU I/O registers
// [R20] Disable: set change-enable and enable, then clear
// [R21] Change-enable clears itself after four cycles
// [R22] Reset flag forces watchdog enable on
// [R23] Select codes give 1K..1M oscillator cycles
// [R24] High-byte write touches only the latch
package iwdt_pkg;

  localparam int CLK_HZ      = 50_000_000;
  localparam int SLOW_OSC_HZ = 90_000;
  localparam int SLOW_DIV    = CLK_HZ / SLOW_OSC_HZ;
  localparam int SLOW_DIV_W  = 10;
  localparam logic [SLOW_DIV_W-1:0] SLOW_LAST = SLOW_DIV_W'(SLOW_DIV - 1);

  localparam int DIV_STAGES = 20;
  localparam int WD_CNT_W   = 3;
  localparam logic [2:0] CE_HOLD_CYCLES = 3'h4;
  localparam logic [4:0] INT_TAP_MAX    = 5'h13;

  localparam int NUM_W16    = 5;
  localparam int NUM_TIMERS = 2;
  // 0: timer B compare, 1: timer B capture, 2: timer C capture, 3/4: timer C compare A/B
  localparam logic [NUM_W16-1:0] W16_TIMER = 5'h1C;

  localparam logic [7:0] ADDR_W16_END = 8'h0A;
  localparam logic [7:0] ADDR_ICR     = 8'h0A;
  localparam logic [7:0] ADDR_WCR     = 8'h0B;
  localparam logic [7:0] ADDR_RSR     = 8'h0C;

  localparam int WCR_CE_BIT      = 4;
  localparam int WCR_EN_BIT      = 3;
  localparam int ICR_SECOND_LSB  = 5;
  localparam int ICR_RESTART_BIT = 4;
  localparam int ICR_IRQEN_BIT   = 3;
  localparam int RSR_WATCHDOG_RESET_FLAG_BIT    = 0;

  typedef enum logic [2:0] {OP_WR8, OP_RD8, OP_WR16, OP_RD16, OP_WD_RESTART, OP_TIMED} host_op_e;

  // Divider bit whose carry-out marks one watchdog step
  function automatic logic [4:0] wd_tap(input logic [2:0] ps);
    case (ps)
      3'h0:    wd_tap = 5'h09;
      3'h1:    wd_tap = 5'h0A;
      3'h2:    wd_tap = 5'h0B;
      3'h3:    wd_tap = 5'h0C;
      3'h4:    wd_tap = 5'h0E;
      3'h5:    wd_tap = 5'h0F;
      3'h6:    wd_tap = 5'h11;
      default: wd_tap = 5'h12 + 5'h01;
    endcase
  endfunction : wd_tap

endpackage : iwdt_pkg

// ### inc/iwdt_if.sv
// Purpose: 8-bit I/O bus between CPU-side end and timer block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Read data answers one cycle after the read strobe
`timescale 1ns/1ps
interface iwdt_if (
  input wire logic clk,
  input wire logic reset
);
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_we;
  logic       io_re;
  logic [7:0] io_rdata;
  logic       watchdog_restart_instr;

  modport device (input clk, reset, io_addr, io_wdata, io_we, io_re, watchdog_restart_instr, output io_rdata);
  modport host   (input clk, reset, io_rdata, output io_addr, io_wdata, io_we, io_re, watchdog_restart_instr);
endinterface : iwdt_if

// ### rtl/iwdt_device.sv
// Purpose: Interval divider, watchdog and shared 16-bit access latches
// Assumes: Fuse input is static; slow oscillator modelled by a clock-enable divider
// Notes:   Chip reset itself is applied outside; this block only requests it
`timescale 1ns/1ps
module iwdt_device
  import iwdt_pkg::*;
(
  iwdt_if.device                         bus,
  input  wire logic                      watchdog_safety_fuse,
  input  wire logic [NUM_W16-1:0]        hw_load,
  input  wire logic [NUM_W16-1:0][15:0]  hw_value,
  output logic      [NUM_W16-1:0][15:0]  word_value,
  output logic                           interval_out_clock,
  output logic                           watchdog_step_clock,
  output logic                           interval_irq,
  output logic                           system_reset_req,
  output logic                           watchdog_active
);

  logic                    clk;
  logic                    reset;
  logic [SLOW_DIV_W-1:0]   slow_cnt_r;
  logic                    slow_tick;
  logic [DIV_STAGES-1:0]   div_r;
  logic [DIV_STAGES-1:0]   int_mask;
  logic [DIV_STAGES-1:0]   wd_mask;
  logic [4:0]              int_tap;
  logic [4:0]              wd_tap_sel;
  logic                    int_tick;
  logic                    wd_step;
  logic                    irq_en_r;
  logic [2:0]              first_sel_r;
  logic [2:0]              second_sel_r;
  logic                    en_r;
  logic [2:0]              ps_r;
  logic [2:0]              ce_cnt_r;
  logic                    ce_live;
  logic [WD_CNT_W-1:0]     wd_cnt_r;
  logic                    wd_ovf;
  logic                    watchdog_reset_flag_r;
  logic                    fuse_s1_r;
  logic                    fuse_s2_r;
  logic [7:0]              tmp_r [NUM_TIMERS];
  logic                    w16_hit;
  logic [2:0]              w16_idx;
  logic                    w16_hi;
  logic                    icr_we;
  logic                    wcr_we;
  logic                    rsr_we;
  logic [7:0]              rd_nxt;
  logic [7:0]              rdata_r;

  assign clk   = bus.clk;
  assign reset = bus.reset;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign w16_hit = bus.io_addr < ADDR_W16_END;
  assign w16_idx = bus.io_addr[3:1];
  assign w16_hi  = bus.io_addr[0];
  assign icr_we  = bus.io_we && bus.io_addr == ADDR_ICR;                    // [R19]
  assign wcr_we  = bus.io_we && bus.io_addr == ADDR_WCR;
  assign rsr_we  = bus.io_we && bus.io_addr == ADDR_RSR;

  ////////////////////////////////////////////////////////////////////////
  // 16-bit registers and shared high-byte latches
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        tmp_r[t] <= 8'h00;
      end
    end else if (w16_hit && w16_hi && bus.io_we) begin
      tmp_r[W16_TIMER[w16_idx]] <= bus.io_wdata;                            // [R24] [R2]
    end else if (w16_hit && !w16_hi && bus.io_re) begin
      tmp_r[W16_TIMER[w16_idx]] <= word_value[w16_idx][15:8];              // [R4]
    end
    // Low-byte writes leave the latch alone so it can be reused  [R7]
  end

  generate
    for (genvar i = 0; i < NUM_W16; i++) begin : g_w16
      localparam int T = W16_TIMER[i];
      // Capture hardware wins over a CPU write in the same cycle
      always_ff @(posedge clk) begin
        if (reset) begin
          word_value[i] <= 16'h0000;
        end else if (hw_load[i]) begin
          word_value[i] <= hw_value[i];
        end else if (bus.io_we && w16_hit && !w16_hi && w16_idx == 3'(i)) begin
          word_value[i] <= {tmp_r[T], bus.io_wdata};                        // [R3] [R1]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Slow oscillator enable and 20-stage divider
  assign slow_tick = slow_cnt_r == SLOW_LAST;

  always_ff @(posedge clk) begin
    if (reset || slow_tick) begin
      slow_cnt_r <= '0;                                                     // [R8]
    end else begin
      slow_cnt_r <= slow_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= '0;                                                          // [R11]
    end else if (icr_we && bus.io_wdata[ICR_RESTART_BIT] && !watchdog_active) begin
      div_r <= '0;                                                          // [R12]
    end else if (slow_tick) begin
      div_r <= div_r + 1'b1;                                                // [R9]
    end
  end

  // A tap fires when every stage up to it is about to carry
  always_comb begin
    int_tap = {2'h0, first_sel_r} + {1'h0, second_sel_r, 1'h0};            // [R10]
    if (int_tap > INT_TAP_MAX) begin
      int_tap = INT_TAP_MAX;
    end
    wd_tap_sel = wd_tap(ps_r);                                              // [R23] [R16]
  end

  generate
    for (genvar b = 0; b < DIV_STAGES; b++) begin : g_mask
      assign int_mask[b] = 5'(b) <= int_tap;
      assign wd_mask[b]  = 5'(b) <= wd_tap_sel;
    end
  endgenerate

  assign int_tick = slow_tick && (&(div_r | ~int_mask));                    // [R9]
  assign wd_step  = slow_tick && (&(div_r | ~wd_mask));                     // [R13]

  ////////////////////////////////////////////////////////////////////////
  // Interval control register
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_en_r     <= 1'b0;
      first_sel_r  <= 3'h0;
      second_sel_r <= 3'h0;
    end else if (icr_we) begin
      irq_en_r     <= bus.io_wdata[ICR_IRQEN_BIT];                          // [R10]
      first_sel_r  <= bus.io_wdata[2:0];
      second_sel_r <= bus.io_wdata[ICR_SECOND_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      interval_out_clock  <= 1'b0;
      watchdog_step_clock <= 1'b0;
      interval_irq        <= 1'b0;
    end else begin
      interval_out_clock  <= int_tick;                                      // [R9]
      watchdog_step_clock <= wd_step;
      interval_irq        <= int_tick && irq_en_r;                          // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog control and timed change window
  // Fuse is a static level from outside; two flops before use
  always_ff @(posedge clk) begin
    if (reset) begin
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
    end else begin
      fuse_s1_r <= watchdog_safety_fuse;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  assign ce_live         = ce_cnt_r != 3'h0;
  assign watchdog_active = en_r || fuse_s2_r || watchdog_reset_flag_r;                     // [R18] [R22]

  always_ff @(posedge clk) begin
    if (reset) begin
      ce_cnt_r <= 3'h0;
    end else if (wcr_we && bus.io_wdata[WCR_CE_BIT] && bus.io_wdata[WCR_EN_BIT]) begin
      ce_cnt_r <= CE_HOLD_CYCLES;                                           // [R20]
    end else if (ce_live) begin
      ce_cnt_r <= ce_cnt_r - 3'h1;                                          // [R21]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      en_r <= 1'b0;                                                         // [R17]
    end else if (wcr_we && bus.io_wdata[WCR_EN_BIT]) begin
      en_r <= 1'b1;
    end else if (wcr_we && ce_live && !fuse_s2_r && !watchdog_reset_flag_r) begin
      en_r <= 1'b0;                                                         // [R20] [R17] [R22]
    end
  end

  // Time-out only moves inside the window, whatever the fuse level
  always_ff @(posedge clk) begin
    if (reset) begin
      ps_r <= 3'h0;
    end else if (wcr_we && ce_live) begin
      ps_r <= bus.io_wdata[2:0];                                            // [R17] [R18] [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counter and reset request
  assign wd_ovf = watchdog_active && !bus.watchdog_restart_instr && wd_step && (&wd_cnt_r);

  always_ff @(posedge clk) begin
    if (reset || bus.watchdog_restart_instr || !watchdog_active) begin
      wd_cnt_r <= '0;                                                       // [R14] [R15]
    end else if (wd_step) begin
      wd_cnt_r <= wd_cnt_r + 1'b1;                                          // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= wd_ovf;                                           // [R13]
    end
  end

  // Flag outlives the chip reset it causes only if the outside keeps
  // this block out of reset; the set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_reset_flag_r <= 1'b0;
    end else if (wd_ovf) begin
      watchdog_reset_flag_r <= 1'b1;
    end else if (rsr_we && !bus.io_wdata[RSR_WATCHDOG_RESET_FLAG_BIT]) begin
      watchdog_reset_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, registered
  always_comb begin
    rd_nxt = 8'h00;
    if (w16_hit) begin
      rd_nxt = w16_hi ? tmp_r[W16_TIMER[w16_idx]] : word_value[w16_idx][7:0]; // [R1]
    end else if (bus.io_addr == ADDR_ICR) begin
      rd_nxt = {second_sel_r, 1'b0, irq_en_r, first_sel_r};
    end else if (bus.io_addr == ADDR_WCR) begin
      rd_nxt = {3'h0, ce_live, watchdog_active, ps_r};
    end else if (bus.io_addr == ADDR_RSR) begin
      rd_nxt = {7'h00, watchdog_reset_flag_r};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (bus.io_re) begin
      rdata_r <= rd_nxt;
    end
  end

  assign bus.io_rdata = rdata_r;

endmodule : iwdt_device

// ### rtl/iwdt_host.sv
// Purpose: CPU-side end turning user commands into I/O bus sequences
// Assumes: Sole master of the bus, so byte pairs are never split
// Notes:   Each command finishes before the next is accepted
`timescale 1ns/1ps
module iwdt_host
  import iwdt_pkg::*;
(
  iwdt_if.host              bus,
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire host_op_e     cmd_op,
  input  wire logic [7:0]   cmd_addr,
  input  wire logic [15:0]  cmd_data,
  output logic              rsp_valid,
  output logic [15:0]       rsp_data
);

  typedef enum logic [2:0] {S_IDLE, S_WR2, S_RD_HI, S_RD_MID, S_RD_LAST} host_state_e;

  host_state_e  state_r;
  host_op_e     op_r;
  logic [7:0]   addr_r;
  logic [15:0]  data_r;
  logic [7:0]   lo_r;
  logic         clk;
  logic         reset;

  assign clk       = bus.clk;
  assign reset     = bus.reset;
  assign cmd_ready = state_r == S_IDLE;

  // One command at a time keeps the latch sequence atomic  [R6]
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r      <= S_IDLE;
      op_r         <= OP_WR8;
      addr_r       <= 8'h00;
      data_r       <= 16'h0000;
      lo_r         <= 8'h00;
      bus.io_addr  <= 8'h00;
      bus.io_wdata <= 8'h00;
      bus.io_we    <= 1'b0;
      bus.io_re    <= 1'b0;
      bus.watchdog_restart_instr      <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= 16'h0000;
    end else begin
      bus.io_we <= 1'b0;
      bus.io_re <= 1'b0;
      bus.watchdog_restart_instr   <= 1'b0;
      rsp_valid <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_valid) begin
            op_r   <= cmd_op;
            addr_r <= cmd_addr;
            data_r <= cmd_data;
            case (cmd_op)
              OP_WR8: begin
                bus.io_addr  <= cmd_addr;
                bus.io_wdata <= cmd_data[7:0];
                bus.io_we    <= 1'b1;
                rsp_valid    <= 1'b1;
              end
              OP_WR16: begin
                bus.io_addr  <= cmd_addr | 8'h01;
                bus.io_wdata <= cmd_data[15:8];                             // [R5] [R1]
                bus.io_we    <= 1'b1;
                state_r      <= S_WR2;
              end
              OP_TIMED: begin
                bus.io_addr  <= ADDR_WCR;
                bus.io_wdata <= 8'h18 | {5'h00, cmd_data[2:0]};            // [R20]
                bus.io_we    <= 1'b1;
                state_r      <= S_WR2;
              end
              OP_RD8: begin
                bus.io_addr <= cmd_addr;
                bus.io_re   <= 1'b1;
                state_r     <= S_RD_MID;
              end
              OP_RD16: begin
                bus.io_addr <= cmd_addr & 8'hFE;                            // [R5]
                bus.io_re   <= 1'b1;
                state_r     <= S_RD_HI;
              end
              OP_WD_RESTART: begin
                bus.watchdog_restart_instr   <= 1'b1;                                          // [R14]
                rsp_valid <= 1'b1;
              end
              default: begin
                rsp_valid <= 1'b1;
              end
            endcase
          end
        end
        S_WR2: begin
          bus.io_we <= 1'b1;
          rsp_valid <= 1'b1;
          state_r   <= S_IDLE;
          if (op_r == OP_TIMED) begin
            bus.io_wdata <= data_r[7:0] & 8'hEF;                            // [R20]
          end else begin
            bus.io_addr  <= addr_r & 8'hFE;
            bus.io_wdata <= data_r[7:0];                                    // [R5]
          end
        end
        S_RD_HI: begin
          bus.io_addr <= addr_r | 8'h01;
          bus.io_re   <= 1'b1;
          state_r     <= S_RD_MID;
        end
        S_RD_MID: begin
          lo_r    <= bus.io_rdata;
          state_r <= S_RD_LAST;
        end
        S_RD_LAST: begin
          rsp_valid <= 1'b1;
          rsp_data  <= (op_r == OP_RD16) ? {bus.io_rdata, lo_r} : {8'h00, bus.io_rdata};
          state_r   <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule : iwdt_host

// ### verif/iwdt_properties.sv
// Purpose: Bus-level properties of the I/O link between host end and timer block
// Assumes: Instantiated beside the interface; sees only its signals
// Notes:   Word and divider outputs are judged by the bench itself
`timescale 1ns/1ps
module iwdt_properties
  import iwdt_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic [7:0] io_rdata,
  input wire logic       watchdog_restart_instr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  logic       open_wr;
  logic [3:0] open_age_r;
  logic [7:0] icr_shadow_r;

  assign open_wr = io_we && io_addr == ADDR_WCR && io_wdata[4:3] == 2'h3;

  // Saturates so an old window never wraps back into range
  always_ff @(posedge clk) begin
    if (reset) open_age_r <= 4'hF;
    else if (open_wr) open_age_r <= 4'h1;
    else if (open_age_r != 4'hF) open_age_r <= open_age_r + 4'h1;
  end

  // Restart bit is a strobe, so it never reads back
  always_ff @(posedge clk) begin
    if (reset) icr_shadow_r <= 8'h00;
    else if (io_we && io_addr == ADDR_ICR) icr_shadow_r <= io_wdata & 8'hEF;
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_strobe_exclusive: assert property (!(io_we && io_re))
    else $error("write and read strobes together");
  chk_rdata_stands: assert property (!$past(io_re) |-> $stable(io_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (io_re && io_addr > ADDR_RSR |=> io_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  chk_icr_readback: assert property (io_re && io_addr == ADDR_ICR |=> io_rdata == $past(icr_shadow_r))
    else $error("interval control readback wrong");
  chk_wcr_reserved: assert property (io_re && io_addr == ADDR_WCR |=> io_rdata[7:5] == 3'h0)
    else $error("watchdog control reserved bits set");
  chk_rsr_reserved: assert property (io_re && io_addr == ADDR_RSR |=> io_rdata[7:1] == 7'h00)
    else $error("reset status reserved bits set");
  chk_window_open: assert property (io_re && io_addr == ADDR_WCR && open_age_r <= 4'h3 |=> io_rdata[4])
    else $error("change enable dropped early");
  chk_window_shut: assert property (io_re && io_addr == ADDR_WCR && open_age_r >= 4'h6 |=> !io_rdata[4])
    else $error("change enable not cleared");
  chk_wdr_pulse: assert property (watchdog_restart_instr |=> !watchdog_restart_instr)
    else $error("watchdog restart longer than one cycle");

  cover property (open_wr);
  cover property (io_re && io_addr == ADDR_WCR && open_age_r <= 4'h3);
  cover property (watchdog_restart_instr);
endmodule : iwdt_properties

// ### verif/interval_watchdog_timer_test.sv
// Purpose: Self-checking bench for host end and timer block joined by their I/O bus
// Assumes: 50 MHz clock; inputs change on the falling edge
// Notes:   Watchdog overflow needs millions of cycles, so it is not reached here
`timescale 1ns/1ps
module interval_watchdog_timer_test
  import iwdt_pkg::*;
;
  logic                     clk;
  logic                     reset;
  logic                     fuse;
  logic                     cmd_valid;
  logic                     cmd_ready;
  host_op_e                 cmd_op;
  logic [7:0]               cmd_addr;
  logic [15:0]              cmd_data;
  logic                     rsp_valid;
  logic [15:0]              rsp_data;
  logic [NUM_W16-1:0]       hw_load;
  logic [NUM_W16-1:0][15:0] hw_value;
  logic [NUM_W16-1:0][15:0] word_value;
  logic                     out_clk;
  logic                     irq;
  logic                     wd_active;
  logic [15:0]              w;
  logic [7:0]               cfg [3] = '{8'h08, 8'h01, 8'h20};
  int                       fails;
  int                       compares;
  int                       out_age;
  int                       out_gap;
  int                       irq_age;
  int                       irq_gap;

  iwdt_if link (.clk(clk), .reset(reset));
  iwdt_device u_iwdt_device (.bus(link), .watchdog_safety_fuse(fuse), .hw_load(hw_load), .hw_value(hw_value),
    .word_value(word_value), .interval_out_clock(out_clk), .watchdog_step_clock(), .interval_irq(irq),
    .system_reset_req(), .watchdog_active(wd_active));
  iwdt_host u_iwdt_host (.bus(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  iwdt_properties u_iwdt_properties (.clk(link.clk), .reset(link.reset), .io_addr(link.io_addr),
    .io_wdata(link.io_wdata), .io_we(link.io_we), .io_re(link.io_re), .io_rdata(link.io_rdata), .watchdog_restart_instr(link.watchdog_restart_instr));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cycles between pulses, so divider periods can be measured
  always @(posedge clk) begin
    out_age <= (out_clk === 1'b1) ? 1 : out_age + 1;
    if (out_clk === 1'b1) out_gap <= out_age;
    irq_age <= (irq === 1'b1) ? 1 : irq_age + 1;
    if (irq === 1'b1) irq_gap <= irq_age;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic run(input host_op_e op, input logic [7:0] addr, input logic [15:0] data);
    int n;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = addr;
    cmd_data = data;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("response", {15'h0, n < 20}, 16'h1);
    // Second byte of a pair lands on the edge after the response, so let it pass
    @(negedge clk);
  endtask : run

  task automatic wr8(input logic [7:0] addr, input logic [7:0] data);
    run(OP_WR8, addr, {8'h00, data});
  endtask : wr8

  task automatic rd8(input logic [7:0] addr, input logic [7:0] exp);
    run(OP_RD8, addr, 16'h0000);
    check("byte read", rsp_data, {8'h00, exp});
  endtask : rd8

  task automatic do_reset();
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask : do_reset

  task automatic wait_age();
    int n;
    n = 0;
    while (out_age != 2000 && n < 10000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_age

  initial begin
    #2_000_000;
    fails++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    fuse = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_WR8;
    cmd_addr = 8'h00;
    cmd_data = 16'h0000;
    hw_load = '0;
    hw_value = '0;
    hw_value[0] = 16'hBEEF;
    fails = 0;
    compares = 0;
    out_age = 0;
    out_gap = 0;
    irq_age = 0;
    irq_gap = 0;
    do_reset();
    rd8(ADDR_ICR, 8'h00);
    rd8(ADDR_WCR, 8'h00);
    rd8(ADDR_RSR, 8'h00);
    check("active", {15'h0, wd_active}, 16'h0);
    repeat (4 * SLOW_DIV + 10) @(negedge clk);
    check("free period", 16'(out_gap), 16'(2 * SLOW_DIV));
    foreach (cfg[i]) begin
      wr8(ADDR_ICR, cfg[i]);
      rd8(ADDR_ICR, cfg[i]);
      repeat ((4 << i) * SLOW_DIV + 10) @(negedge clk);
      check("period", 16'(out_gap), 16'((2 << i) * SLOW_DIV));
    end
    check("irq period", 16'(irq_gap), 16'(2 * SLOW_DIV));
    check("irq masked", {15'h0, irq_age > 8 * SLOW_DIV}, 16'h1);
    wait_age();
    wr8(ADDR_ICR, 8'h30);
    repeat (10 * SLOW_DIV) @(negedge clk);
    check("restarted", {15'h0, out_gap > 8 * SLOW_DIV}, 16'h1);
    wr8(ADDR_WCR, 8'h08);
    check("active", {15'h0, wd_active}, 16'h1);
    wait_age();
    wr8(ADDR_ICR, 8'h30);
    repeat (10 * SLOW_DIV) @(negedge clk);
    check("no restart", 16'(out_gap), 16'(8 * SLOW_DIV));
    wr8(ADDR_WCR, 8'h05);
    rd8(ADDR_WCR, 8'h08);
    run(OP_TIMED, ADDR_WCR, 16'h000A);
    rd8(ADDR_WCR, 8'h1A);
    repeat (10) @(negedge clk);
    rd8(ADDR_WCR, 8'h0A);
    run(OP_WD_RESTART, 8'h00, 16'h0000);
    run(OP_TIMED, ADDR_WCR, 16'h0000);
    check("disabled", {15'h0, wd_active}, 16'h0);
    // Change-enable still reads one until its window has run out
    repeat (10) @(negedge clk);
    rd8(ADDR_WCR, 8'h00);
    wr8(8'h20, 8'hFF);
    rd8(8'h20, 8'h00);
    for (int i = 0; i < NUM_W16; i++) begin
      w = 16'hA05C + 16'(i * 16'h0101);
      run(OP_WR16, 8'(2 * i), w);
      check("word", word_value[i], w);
      run(OP_RD16, 8'(2 * i), 16'h0000);
      check("word read", rsp_data, w);
    end
    wr8(8'h01, 8'hA5);
    check("word0 held", word_value[0], 16'hA05C);
    wr8(8'h00, 8'h3C);
    check("word0", word_value[0], 16'hA53C);
    wr8(8'h02, 8'h11);
    check("word1 reuse", word_value[1], 16'hA511);
    wr8(8'h05, 8'h77);
    wr8(8'h00, 8'h22);
    check("word0 own latch", word_value[0], 16'hA522);
    check("word2 held", word_value[2], 16'hA25E);
    rd8(8'h00, 8'h22);
    hw_load = 5'h01;
    @(negedge clk);
    hw_load = 5'h00;
    check("capture", word_value[0], 16'hBEEF);
    rd8(8'h01, 8'hA5);
    fuse = 1'b1;
    do_reset();
    check("fuse active", {15'h0, wd_active}, 16'h1);
    rd8(ADDR_WCR, 8'h08);
    run(OP_TIMED, ADDR_WCR, 16'h0003);
    repeat (10) @(negedge clk);
    rd8(ADDR_WCR, 8'h0B);
    check("still active", {15'h0, wd_active}, 16'h1);
    give_verdict();
  end
endmodule : interval_watchdog_timer_test
